/* rcrb_bank.sv */
/*
 * Register bank for two step-down converter channels and two linear
 * regulators, with the effective enable and analog control outputs.
 * Assumes a serial-port front end presents decoded byte writes and reads
 * synchronous to sys_clk_in; the enable pin is synchronous as well.
 */
// Notes on behaviour
// [R1] Current limit codes 0..3 select 1.5 A to 3.0 A; 4..7 reserved.
// [R2] A current limit write applies at once, even while the converter runs.
// [R3] Ramp rate codes 2..7 select 10 down to 0.47 mV/us; 0,1 reserved.
// [R4] Mode bit 3: 0 automatic PFM/PWM, 1 forced PWM.
// [R5] Discharge bit 2 connects the resistor while disabled; resets to 1. Converter 0's discharge output is tied to one, even while it is on.
// [R6] Pin qualify 0 follows software bit; 1 also needs the enable pin.
// [R7] Software enable bit 0 turns the regulator on or off.
// [R8] Voltage codes 0x00..0x13 reserved; 0x14..0x17 step 10 mV from 0.70 V.
// [R9] Voltage codes 0x18..0x9d step 5 mV from 0.735 V to 1.4 V.
// [R10] Voltage codes 0x9e..0xff step 20 mV from 1.42 V to 3.36 V.
// [R11] First linear regulator has discharge, pin qualify and enable bits.
// [R12] Host never writes reserved codes and keeps reserved bits at default.
// [R13] Effective enable is software bit AND (pin if qualified else one). Converter 0's enable is the pin alone.
`timescale 1ns/1ps
`default_nettype none
`include "rcrb_params.svh"

module rcrb_bank
    import rcrb_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Register access port.
    input wire logic wr_en_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] rdata_out,
    output logic addr_hit_out,
    // Enable pin.
    input wire logic en_pin_in,
    // Regulator controls.
    output rcrb_conv_ctl_t conv0_ctl_out,
    output rcrb_conv_ctl_t conv1_ctl_out,
    output rcrb_lin_ctl_t lin0_ctl_out,
    output rcrb_lin_ctl_t lin1_ctl_out
);
    logic [7:0] c0_limslew_q, c1_modeen_q, c1_limslew_q;
    logic [7:0] c0_vcode_q, c1_vcode_q, l0_en_q, l1_en_q;

    wire wr_c0_ls = wr_en_in && addr_in == `RCRB_OFF_C0_LIMSLEW;
    wire wr_c1_me = wr_en_in && addr_in == `RCRB_OFF_C1_MODEEN;
    wire wr_c1_ls = wr_en_in && addr_in == `RCRB_OFF_C1_LIMSLEW;
    wire wr_c0_v = wr_en_in && addr_in == `RCRB_OFF_C0_VCODE;
    wire wr_c1_v = wr_en_in && addr_in == `RCRB_OFF_C1_VCODE;
    wire wr_l0 = wr_en_in && addr_in == `RCRB_OFF_L0_EN;
    wire wr_l1 = wr_en_in && addr_in == `RCRB_OFF_L1_EN;

    // Reserved bits are stored as written; the host keeps them at default.
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            c0_limslew_q <= `RCRB_RST_LIMSLEW;
            c1_modeen_q <= `RCRB_RST_MODEEN; // [R5]
            c1_limslew_q <= `RCRB_RST_LIMSLEW;
            c0_vcode_q <= `RCRB_RST_VCODE;
            c1_vcode_q <= `RCRB_RST_VCODE;
            l0_en_q <= `RCRB_RST_LINEN; // [R5]
            l1_en_q <= `RCRB_RST_LINEN;
        end else begin
            if (wr_c0_ls) c0_limslew_q <= wdata_in; // [R2]
            if (wr_c1_me) c1_modeen_q <= wdata_in; // [R7]
            if (wr_c1_ls) c1_limslew_q <= wdata_in; // [R2]
            if (wr_c0_v) c0_vcode_q <= wdata_in;
            if (wr_c1_v) c1_vcode_q <= wdata_in;
            if (wr_l0) l0_en_q <= wdata_in; // [R11]
            if (wr_l1) l1_en_q <= wdata_in;
        end
    end

    // Reads are combinational, so the access port sees a register in the
    // same cycle that it presents the offset; unmapped offsets read zero.
    wire [7:0] rd_mux =
        addr_in == `RCRB_OFF_C0_LIMSLEW ? c0_limslew_q :
        addr_in == `RCRB_OFF_C1_MODEEN ? c1_modeen_q :
        addr_in == `RCRB_OFF_C1_LIMSLEW ? c1_limslew_q :
        addr_in == `RCRB_OFF_C0_VCODE ? c0_vcode_q :
        addr_in == `RCRB_OFF_C1_VCODE ? c1_vcode_q :
        addr_in == `RCRB_OFF_L0_EN ? l0_en_q :
        addr_in == `RCRB_OFF_L1_EN ? l1_en_q : 8'h00;
    assign rdata_out = rd_mux;
    assign addr_hit_out = addr_in >= `RCRB_OFF_C0_LIMSLEW &&
                          addr_in <= `RCRB_OFF_L1_EN;

    function automatic logic qual_on(input logic [7:0] r, input logic pin);
        // A qualified regulator needs the pin; otherwise a constant one.
        qual_on = r[`RCRB_BIT_SW_ON] &&
                  (r[`RCRB_BIT_PIN_QUAL] ? pin : 1'b1); // [R13]
    endfunction

    function automatic rcrb_vrange_t vrange(input logic [7:0] c);
        if (c < `RCRB_V10_LO) vrange = RCRB_V_RESERVED; // [R8]
        else if (c < `RCRB_V5_LO) vrange = RCRB_V_STEP10; // [R8]
        else if (c < `RCRB_V20_LO) vrange = RCRB_V_STEP5; // [R9]
        else vrange = RCRB_V_STEP20; // [R10]
    endfunction

    // Converter 0's mode and enable live in a register outside this bank,
    // so its enable comes from the pin alone and its mode is automatic.
    wire c0_on = en_pin_in;
    wire [7:0] c0_v = c0_vcode_q;
    wire [7:0] c1_v = c1_vcode_q;
    wire [2:0] c0_lim = c0_limslew_q[`RCRB_LIM_LSB +: 3]; // [R1]
    wire [2:0] c0_ramp = c0_limslew_q[`RCRB_RAMP_LSB +: 3]; // [R3]
    wire [2:0] c1_lim = c1_limslew_q[`RCRB_LIM_LSB +: 3]; // [R1]
    wire [2:0] c1_ramp = c1_limslew_q[`RCRB_RAMP_LSB +: 3]; // [R3]
    wire c0_fault = c0_lim > `RCRB_LIM_MAX || c0_ramp < `RCRB_RAMP_MIN ||
                    vrange(c0_v) == RCRB_V_RESERVED; // [R12]
    wire c1_fault = c1_lim > `RCRB_LIM_MAX || c1_ramp < `RCRB_RAMP_MIN ||
                    vrange(c1_v) == RCRB_V_RESERVED; // [R12]
    wire c1_on = qual_on(c1_modeen_q, en_pin_in); // [R6] [R7]
    wire l0_on = qual_on(l0_en_q, en_pin_in); // [R11]
    wire l1_on = qual_on(l1_en_q, en_pin_in);

    assign conv0_ctl_out = '{on: c0_on,
        discharge: 1'b1,
        force_pwm: 1'b0,
        current_limit: c0_lim,
        ramp_rate: c0_ramp,
        voltage_code: c0_v,
        vrange: vrange(c0_v),
        code_fault: c0_fault};
    assign conv1_ctl_out = '{on: c1_on,
        discharge: c1_modeen_q[`RCRB_BIT_DISCH] && !c1_on, // [R5]
        force_pwm: c1_modeen_q[`RCRB_BIT_FPWM], // [R4]
        current_limit: c1_lim,
        ramp_rate: c1_ramp,
        voltage_code: c1_v,
        vrange: vrange(c1_v),
        code_fault: c1_fault};
    assign lin0_ctl_out = '{on: l0_on,
        discharge: l0_en_q[`RCRB_BIT_DISCH] && !l0_on}; // [R11]
    assign lin1_ctl_out = '{on: l1_on,
        discharge: l1_en_q[`RCRB_BIT_DISCH] && !l1_on};

    // The write-follow checks look one cycle back, so they stay off while
    // reset is low and cannot blame the first cycle after it on a stale strobe.
    c1_limit_live_a: assert property (@(posedge sys_clk_in) // [R2]
        disable iff (!rst_n_in)
        wr_c1_ls |=> conv1_ctl_out.current_limit ==
            $past(wdata_in[`RCRB_LIM_LSB +: 3]))
        else $error("current limit write did not apply");
    c0_limit_live_a: assert property (@(posedge sys_clk_in) // [R2]
        disable iff (!rst_n_in)
        wr_c0_ls |=> conv0_ctl_out.current_limit ==
            $past(wdata_in[`RCRB_LIM_LSB +: 3]))
        else $error("converter 0 limit write did not apply");
    c1_ramp_live_a: assert property (@(posedge sys_clk_in) // [R3]
        disable iff (!rst_n_in)
        wr_c1_ls |=> conv1_ctl_out.ramp_rate ==
            $past(wdata_in[`RCRB_RAMP_LSB +: 3]))
        else $error("ramp rate write did not apply");
    c0_vcode_live_a: assert property (@(posedge sys_clk_in) // [R8]
        disable iff (!rst_n_in)
        wr_c0_v |=> conv0_ctl_out.voltage_code == $past(wdata_in))
        else $error("voltage code write did not apply");

    c1_enable_qual_a: assert property (@(posedge sys_clk_in) // [R6]
        disable iff (!rst_n_in)
        c1_modeen_q[`RCRB_BIT_PIN_QUAL] && !en_pin_in |-> !conv1_ctl_out.on)
        else $error("qualified converter on without pin");
    c1_sw_on_a: assert property (@(posedge sys_clk_in) // [R7]
        disable iff (!rst_n_in)
        wr_c1_me && wdata_in[`RCRB_BIT_SW_ON] &&
        !wdata_in[`RCRB_BIT_PIN_QUAL] |=> conv1_ctl_out.on)
        else $error("software enable did not turn converter on");
    c1_mode_a: assert property (@(posedge sys_clk_in) // [R4]
        disable iff (!rst_n_in)
        wr_c1_me |=> conv1_ctl_out.force_pwm ==
            $past(wdata_in[`RCRB_BIT_FPWM]))
        else $error("mode bit not followed");
    l0_discharge_a: assert property (@(posedge sys_clk_in) // [R11]
        disable iff (!rst_n_in)
        lin0_ctl_out.discharge |-> !lin0_ctl_out.on)
        else $error("discharge while enabled");
    disch_reset_a: assert property (@(posedge sys_clk_in) // [R5]
        $rose(rst_n_in) |-> c1_modeen_q[`RCRB_BIT_DISCH] &&
            l0_en_q[`RCRB_BIT_DISCH])
        else $error("discharge bit not reset to one");
    v_step5_a: assert property (@(posedge sys_clk_in) // [R9]
        disable iff (!rst_n_in)
        c0_v == 8'h9d |-> conv0_ctl_out.vrange == RCRB_V_STEP5)
        else $error("0x9d outside 5 mV range");
    v_step20_a: assert property (@(posedge sys_clk_in) // [R10]
        disable iff (!rst_n_in)
        c0_v == 8'h9e |-> conv0_ctl_out.vrange == RCRB_V_STEP20)
        else $error("0x9e outside 20 mV range");
    v_reserved_a: assert property (@(posedge sys_clk_in) // [R8]
        disable iff (!rst_n_in)
        c1_v == 8'h13 |-> conv1_ctl_out.code_fault)
        else $error("reserved voltage code not flagged");
    lim_reserved_a: assert property (@(posedge sys_clk_in) // [R1]
        disable iff (!rst_n_in)
        c1_lim == 3'h4 |-> conv1_ctl_out.code_fault)
        else $error("reserved limit code not flagged");
    ramp_reserved_a: assert property (@(posedge sys_clk_in) // [R3]
        disable iff (!rst_n_in)
        c0_ramp == 3'h1 |-> conv0_ctl_out.code_fault)
        else $error("reserved ramp code not flagged");
    l0_enable_a: assert property (@(posedge sys_clk_in) // [R13]
        disable iff (!rst_n_in)
        lin0_ctl_out.on == (l0_en_q[`RCRB_BIT_SW_ON] &&
            (!l0_en_q[`RCRB_BIT_PIN_QUAL] || en_pin_in)))
        else $error("linear enable equation broken");
    c1_sw_off_a: assert property (@(posedge sys_clk_in) // [R7]
        disable iff (!rst_n_in)
        wr_c1_me && !wdata_in[`RCRB_BIT_SW_ON] |=> !conv1_ctl_out.on)
        else $error("software disable did not turn converter off");
    c1_discharge_a: assert property (@(posedge sys_clk_in) // [R5]
        disable iff (!rst_n_in)
        c1_modeen_q[`RCRB_BIT_DISCH] && !conv1_ctl_out.on |->
            conv1_ctl_out.discharge)
        else $error("discharge resistor off while disabled");
    l1_enable_qual_a: assert property (@(posedge sys_clk_in) // [R6]
        disable iff (!rst_n_in)
        l1_en_q[`RCRB_BIT_PIN_QUAL] && !en_pin_in |-> !lin1_ctl_out.on)
        else $error("qualified linear regulator on without pin");
    v_step10_a: assert property (@(posedge sys_clk_in) // [R8]
        disable iff (!rst_n_in)
        c1_v == `RCRB_V10_LO |-> conv1_ctl_out.vrange == RCRB_V_STEP10)
        else $error("0x14 outside 10 mV range");
endmodule

`default_nettype wire

/* rcrb_params.svh */
/*
 * Offsets, field positions, reset values and code boundaries of the
 * regulator control register bank.
 * Assumes it is included by bare name from the design.
 */
`ifndef RCRB_PARAMS_SVH
`define RCRB_PARAMS_SVH

`define RCRB_OFF_C0_LIMSLEW 8'h03
`define RCRB_OFF_C1_MODEEN 8'h04
`define RCRB_OFF_C1_LIMSLEW 8'h05
`define RCRB_OFF_C0_VCODE 8'h06
`define RCRB_OFF_C1_VCODE 8'h07
`define RCRB_OFF_L0_EN 8'h08
`define RCRB_OFF_L1_EN 8'h09

`define RCRB_BIT_SW_ON 0
`define RCRB_BIT_PIN_QUAL 1
`define RCRB_BIT_DISCH 2
`define RCRB_BIT_FPWM 3
`define RCRB_LIM_LSB 3
`define RCRB_RAMP_LSB 0

`define RCRB_RST_LIMSLEW 8'h00
`define RCRB_RST_MODEEN 8'h04
`define RCRB_RST_VCODE 8'h00
`define RCRB_RST_LINEN 8'h04

`define RCRB_LIM_MAX 3'h3
`define RCRB_RAMP_MIN 3'h2
`define RCRB_V10_LO 8'h14
`define RCRB_V5_LO 8'h18
`define RCRB_V20_LO 8'h9e

`endif

/* rcrb_pkg.sv */
/*
 * Types shared by the regulator control register bank.
 * Assumes the constants header is on the include path.
 */
package rcrb_pkg;
    typedef enum logic [1:0] {
        RCRB_V_RESERVED,
        RCRB_V_STEP10,
        RCRB_V_STEP5,
        RCRB_V_STEP20
    } rcrb_vrange_t;

    typedef struct packed {
        logic on;
        logic discharge;
        logic force_pwm;
        logic [2:0] current_limit;
        logic [2:0] ramp_rate;
        logic [7:0] voltage_code;
        rcrb_vrange_t vrange;
        logic code_fault;
    } rcrb_conv_ctl_t;

    typedef struct packed {
        logic on;
        logic discharge;
    } rcrb_lin_ctl_t;
endpackage

/* rcrb_host.sv */
/* Host model that writes and reads the register bank's access port.
   Assumes a free-running clock; it changes its outputs on rising edges. */
`timescale 1ns/1ps
`default_nettype none
module rcrb_host (
    // Clock.
    input wire logic sys_clk_in,
    // Access port.
    output logic wr_en_out,
    output logic [7:0] addr_out,
    output logic [7:0] wdata_out,
    input wire logic [7:0] rdata_in
);
    initial begin
        wr_en_out = 1'b0;
        addr_out = 8'h00;
        wdata_out = 8'h00;
    end
    // Data is inverted after the strobe so a stale byte is never taken.
    // Callers hand over legal codes with reserved bits at zero.
    task automatic write_reg(input logic [7:0] a,
        input logic [7:0] d);
        @(posedge sys_clk_in);
        wr_en_out <= 1'b1;
        addr_out <= a;
        wdata_out <= d;
        @(posedge sys_clk_in);
        wr_en_out <= 1'b0;
        wdata_out <= ~d;
    endtask
    // The offset stands a whole cycle; the data is taken at the next edge.
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk_in);
        addr_out <= a;
        @(posedge sys_clk_in);
        d = rdata_in;
    endtask
endmodule
`default_nettype wire

/* rcrb_bank_test.sv */
/* Self-checking bench for the regulator control register bank.
   Assumes the host model file and the bank's package are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module rcrb_bank_test;
    import rcrb_pkg::*;
    logic sys_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic en_pin_in = 1'b0;
    logic wr_en, hit;
    logic [7:0] addr, wdata, rdata, v, w;
    rcrb_conv_ctl_t c0, c1;
    rcrb_lin_ctl_t l0, l1;
    logic [7:0] rst_val [7] = '{8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h04,
        8'h04};
    logic [7:0] codes [6] = '{8'h14, 8'h17, 8'h18, 8'h9d, 8'h9e, 8'hff};
    logic [1:0] rng [6] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;
    always #50 sys_clk_in = ~sys_clk_in;
    rcrb_host host (.sys_clk_in(sys_clk_in), .wr_en_out(wr_en),
        .addr_out(addr), .wdata_out(wdata), .rdata_in(rdata));
    rcrb_bank DUT (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .wr_en_in(wr_en), .addr_in(addr), .wdata_in(wdata),
        .rdata_out(rdata), .addr_hit_out(hit), .en_pin_in(en_pin_in),
        .conv0_ctl_out(c0), .conv1_ctl_out(c1), .lin0_ctl_out(l0),
        .lin1_ctl_out(l1));
    task automatic chk(input string n, input logic [7:0] e,
        input logic [7:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        host.read_reg(a, v);
        chk("read data", e, v);
    endtask
    task automatic summarize();
        $display("checks %0d, errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // The whole sequence needs well under a thousand cycles.
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            summarize();
        end
    end
    initial begin
        repeat (12) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        for (int i = 0; i < 7; i++) rd(8'h03 + 8'(i), rst_val[i]);
        chk("rst range", 8'h00, {4'h0, c0.vrange, c1.vrange});
        chk("rst fault", 8'h03, {6'h0, c0.code_fault,
            c1.code_fault});
        chk("c0 fixed", 8'h02, {6'h0, c0.discharge, c0.force_pwm});
        host.write_reg(8'h0a, 8'hff);
        rd(8'h0a, 8'h00);
        chk("hit", 8'h00, {7'h0, hit});
        rd(8'h09, 8'h04);
        chk("hit", 8'h01, {7'h0, hit});
        host.write_reg(8'h04, 8'h09);
        rd(8'h04, 8'h09);
        chk("c1 mode", 8'h06, {5'h0, c1.on, c1.force_pwm,
            c1.discharge});
        host.write_reg(8'h04, 8'h07);
        host.write_reg(8'h08, 8'h07);
        host.write_reg(8'h09, 8'h07);
        for (int p = 0; p < 2; p++) begin
            @(posedge sys_clk_in);
            en_pin_in <= p[0];
            rd(8'h08, 8'h07);
            chk("enables", p ? 8'h6a : 8'h15, {1'b0, c0.on, c1.on,
                c1.discharge, l0.on, l0.discharge, l1.on,
                l1.discharge});
        end
        @(posedge sys_clk_in);
        en_pin_in <= 1'b0;
        host.write_reg(8'h08, 8'h01);
        host.write_reg(8'h04, 8'h01);
        rd(8'h08, 8'h01);
        chk("sw only", 8'h03, {6'h0, l0.on, c1.on});
        for (int k = 0; k < 6; k++) begin
            w = {3'h0, 2'(k), 3'(k + 2)};
            host.write_reg(8'h03, w);
            host.write_reg(8'h05, w);
            rd(8'h05, w);
            chk("c0 limit", w,
                {2'h0, c0.current_limit, c0.ramp_rate});
            chk("c1 limit", w | 8'h80,
                {c1.on, 1'b0, c1.current_limit, c1.ramp_rate});
        end
        for (int i = 0; i < 6; i++) begin
            host.write_reg(8'h06, codes[i]);
            host.write_reg(8'h07, codes[i]);
            rd(8'h06, codes[i]);
            chk("c0 code", codes[i], c0.voltage_code);
            chk("c1 code", codes[i], c1.voltage_code);
            chk("range", {4'h0, rng[i], rng[i]},
                {4'h0, c0.vrange, c1.vrange});
        end
        chk("fault", 8'h00, {6'h0, c0.code_fault, c1.code_fault});
        host.write_reg(8'h04, 8'h0c);
        rd(8'h04, 8'h0c);
        chk("c1 off", 8'h03, {5'h0, c1.on, c1.force_pwm,
            c1.discharge});
        @(posedge sys_clk_in);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        rd(8'h04, 8'h04);
        rd(8'h08, 8'h04);
        chk("rst ctl", 8'h15, {1'b0, c0.on, c1.on, c1.discharge, l0.on,
            l0.discharge, l1.on, l1.discharge});
        summarize();
    end
endmodule
`default_nettype wire
